// ===== src/aie_defines.vh
// Constants for the accumulator instruction execution block.
// Assumes inclusion by bare name from the design files under src/.
`ifndef AIE_DEFINES_VH
`define AIE_DEFINES_VH

// ****************************************************************
// Timing
// ****************************************************************
`define AIE_MC_CLKS      8'd12
`define AIE_LEN_W        2
`define AIE_CYC_W        3

// ****************************************************************
// Special function register addresses (direct space, top half)
// ****************************************************************
`define AIE_SFR_ACC      8'he0
`define AIE_SFR_B        8'hf0
`define AIE_SFR_PSW      8'hd0
`define AIE_SFR_DPL      8'h82
`define AIE_SFR_DPH      8'h83

// ****************************************************************
// Status word fields
// ****************************************************************
`define AIE_PSW_CY       7
`define AIE_PSW_AC       6
`define AIE_PSW_RS1      4
`define AIE_PSW_RS0      3
`define AIE_PSW_OV       2
`define AIE_PSW_P        0

// ****************************************************************
// Reset values
// ****************************************************************
`define AIE_RST_ACC      8'h00
`define AIE_RST_B        8'h00
`define AIE_RST_PSW      8'h00
`define AIE_RST_DATA_POINTER_16     16'h0000

// ****************************************************************
// Opcodes and opcode groups (upper nibble)
// ****************************************************************
`define AIE_OP_INC_DATA_POINTER_16  8'ha3
`define AIE_OP_MUL       8'ha4
`define AIE_OP_DIV       8'h84
`define AIE_OP_DA        8'hd4
`define AIE_OP_CLR_A     8'he4
`define AIE_GRP_INC      4'h0
`define AIE_GRP_DEC      4'h1
`define AIE_GRP_ADD      4'h2
`define AIE_GRP_ADD_WITH_CARRY     4'h3
`define AIE_GRP_OR       4'h4
`define AIE_GRP_AND      4'h5
`define AIE_GRP_XOR      4'h6
`define AIE_GRP_SUBTRACT_WITH_BORROW     4'h9

// ****************************************************************
// ALU operations
// ****************************************************************
`define AIE_ALU_ADD      4'h0
`define AIE_ALU_ADD_WITH_CARRY     4'h1
`define AIE_ALU_SUBTRACT_WITH_BORROW     4'h2
`define AIE_ALU_AND      4'h3
`define AIE_ALU_OR       4'h4
`define AIE_ALU_XOR      4'h5
`define AIE_ALU_INC      4'h6
`define AIE_ALU_DEC      4'h7
`define AIE_ALU_DA       4'h8

`endif

// ===== src/aie_alu.v
// Byte ALU: add, add with carry, subtract with borrow, logic,
// increment, decrement and decimal adjust. Purely combinational;
// the caller registers the results.
`timescale 1ns/100ps
`include "aie_defines.vh"

module aie_alu (
    // Operands
    input  wire [7:0] a_i,
    input  wire [7:0] b_i,
    input  wire       cy_i,
    input  wire       ac_i,
    input  wire [3:0] op_i,
    // Results
    output reg  [7:0] res_o,
    output reg        cy_o,
    output reg        ac_o,
    output reg        ov_o
);

    reg [8:0] sum;
    reg [4:0] nib;
    reg [8:0] adj;

    always @* begin
        sum   = 9'h000;
        nib   = 5'h00;
        adj   = 9'h000;
        res_o = 8'h00;
        cy_o  = cy_i;
        ac_o  = ac_i;
        ov_o  = 1'b0;
        case (op_i)
            `AIE_ALU_ADD, `AIE_ALU_ADD_WITH_CARRY: begin
                sum = {1'b0, a_i} + {1'b0, b_i} +
                      {8'h00, cy_i & (op_i == `AIE_ALU_ADD_WITH_CARRY)};
                nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} +
                      {4'h0, cy_i & (op_i == `AIE_ALU_ADD_WITH_CARRY)};
                res_o = sum[7:0];
                cy_o  = sum[8];
                ac_o  = nib[4];
                ov_o  = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
            end
            `AIE_ALU_SUBTRACT_WITH_BORROW: begin
                // Borrow is the carry flag, taken out along with b
                sum = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cy_i};
                nib = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} -
                      {4'h0, cy_i};
                res_o = sum[7:0];
                cy_o  = sum[8];
                ac_o  = nib[4];
                ov_o  = (a_i[7] != b_i[7]) && (sum[7] != a_i[7]);
            end
            `AIE_ALU_AND: res_o = a_i & b_i;
            `AIE_ALU_OR:  res_o = a_i | b_i;
            `AIE_ALU_XOR: res_o = a_i ^ b_i;
            `AIE_ALU_INC: res_o = a_i + 8'h01;
            `AIE_ALU_DEC: res_o = a_i - 8'h01;
            `AIE_ALU_DA: begin
                adj = {1'b0, a_i};
                if (ac_i || (adj[3:0] > 4'h9)) begin
                    adj = adj + 9'h006;
                end
                if (cy_i || adj[8] || (adj[7:4] > 4'h9)) begin
                    adj = adj + 9'h060;
                    cy_o = 1'b1;
                end
                res_o = adj[7:0];
            end
            default: res_o = a_i;
        endcase
    end

endmodule

// ===== src/aie_exec.v
// Execution of arithmetic and logical instructions of a byte-wide
// accumulator core, with its own accumulator, B, status word, data
// pointer and 256-byte internal data memory.
// Assumes one clock, instructions handed in already fetched with
// their operand bytes, and a load port used only while idle.
`timescale 1ns/100ps
`include "aie_defines.vh"

module aie_exec #(
    parameter [7:0] MC_CLKS = `AIE_MC_CLKS
) (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        rstn_i,
    // Instruction issue
    input  wire        instr_valid_i,
    output wire        instr_ready_o,
    input  wire [7:0]  opcode_i,
    input  wire [7:0]  operand1_i,
    input  wire [7:0]  operand2_i,
    // Completion
    output wire        done_o,
    output wire        illegal_o,
    output wire [1:0]  instr_len_o,
    output wire [2:0]  instr_cycles_o,
    output wire [15:0] rel_offset_o,
    // Core state
    output wire [7:0]  acc_o,
    output wire [7:0]  b_o,
    output wire [7:0]  psw_o,
    output wire [15:0] data_pointer_16_o,
    // Data memory load port
    input  wire        mem_wr_i,
    input  wire [7:0]  mem_addr_i,
    input  wire [7:0]  mem_wdata_i,
    output wire [7:0]  mem_rdata_o
);

    // ************************************************************
    // Reset release
    // ************************************************************
    reg  [1:0] rst_sync_ff;
    wire       rst_n = rst_sync_ff[1];

    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    // ************************************************************
    // Instruction shape: legal, length in bytes, machine cycles
    // ************************************************************
    function [5:0] aie_shape;
        input [7:0] op;
        reg   [3:0] hi;
        reg   [3:0] lo;
        reg         logic_g;
        reg         arith_g;
        reg         step_g;
        begin
            hi      = op[7:4];
            lo      = op[3:0];
            logic_g = (hi == `AIE_GRP_AND) || (hi == `AIE_GRP_OR) ||
                      (hi == `AIE_GRP_XOR);
            arith_g = (hi == `AIE_GRP_ADD) || (hi == `AIE_GRP_ADD_WITH_CARRY) ||
                      (hi == `AIE_GRP_SUBTRACT_WITH_BORROW);
            step_g  = (hi == `AIE_GRP_INC) || (hi == `AIE_GRP_DEC);
            aie_shape = {1'b0, 2'd1, 3'd1};
            if (op == `AIE_OP_INC_DATA_POINTER_16) begin
                aie_shape = {1'b1, 2'd1, 3'd2};
            end else if (op == `AIE_OP_MUL || op == `AIE_OP_DIV) begin
                aie_shape = {1'b1, 2'd1, 3'd4};
            end else if (op == `AIE_OP_DA || op == `AIE_OP_CLR_A) begin
                aie_shape = {1'b1, 2'd1, 3'd1};
            end else if (logic_g && lo == 4'h3) begin
                aie_shape = {1'b1, 2'd3, 3'd2};
            end else if (logic_g && lo == 4'h2) begin
                aie_shape = {1'b1, 2'd2, 3'd1};
            end else if ((logic_g || arith_g) && lo >= 4'h4) begin
                // Immediate and direct take a second byte
                if (lo == 4'h4 || lo == 4'h5) begin
                    aie_shape = {1'b1, 2'd2, 3'd1};
                end else begin
                    aie_shape = {1'b1, 2'd1, 3'd1};
                end
            end else if (step_g && lo >= 4'h4) begin
                aie_shape = {1'b1, (lo == 4'h5) ? 2'd2 : 2'd1, 3'd1};
            end
        end
    endfunction

    wire [5:0] in_shape = aie_shape(opcode_i);

    // ************************************************************
    // Sequencing: one machine cycle is MC_CLKS clock cycles
    // ************************************************************
    reg        busy_ff;
    reg  [7:0] op_ff;
    reg  [7:0] opnd1_ff;
    reg  [7:0] opnd2_ff;
    reg        legal_ff;
    reg  [1:0] len_ff;
    reg  [2:0] cyc_ff;
    reg  [2:0] left_ff;
    reg  [7:0] phase_ff;
    reg        done_ff;
    reg        illegal_ff;
    reg [15:0] rel_ff;

    wire mc_tick = (phase_ff == MC_CLKS - 8'h01);
    wire commit  = busy_ff && mc_tick && (left_ff == 3'd1);

    assign instr_ready_o = ~busy_ff & rst_n;

    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            busy_ff    <= 1'b0;
            op_ff      <= 8'h00;
            opnd1_ff   <= 8'h00;
            opnd2_ff   <= 8'h00;
            legal_ff   <= 1'b0;
            len_ff     <= 2'd0;
            cyc_ff     <= 3'd0;
            left_ff    <= 3'd0;
            phase_ff   <= 8'h00;
            done_ff    <= 1'b0;
            illegal_ff <= 1'b0;
            rel_ff     <= 16'h0000;
        end else begin
            done_ff    <= commit;
            illegal_ff <= commit & ~legal_ff;
            if (!busy_ff) begin
                if (instr_valid_i) begin
                    busy_ff  <= 1'b1;
                    op_ff    <= opcode_i;
                    opnd1_ff <= operand1_i;
                    opnd2_ff <= operand2_i;
                    legal_ff <= in_shape[5];
                    len_ff   <= in_shape[4:3];
                    cyc_ff   <= in_shape[2:0];
                    left_ff  <= in_shape[2:0];
                    phase_ff <= 8'h00;
                    rel_ff   <= {{8{operand1_i[7]}}, operand1_i};
                end
            end else if (mc_tick) begin
                phase_ff <= 8'h00;
                left_ff  <= left_ff - 3'd1;
                if (left_ff == 3'd1) begin
                    busy_ff <= 1'b0;
                end
            end else begin
                phase_ff <= phase_ff + 8'h01;
            end
        end
    end

    // ************************************************************
    // Operand fetch
    // ************************************************************
    reg  [7:0] iram [0:255];
    reg  [7:0] acc_ff;
    reg  [7:0] b_ff;
    reg  [7:0] psw_ff;
    reg [15:0] data_pointer_16_ff;
    reg  [7:0] mem_rdata_ff;

    wire [3:0] hi       = op_ff[7:4];
    wire [3:0] lo       = op_ff[3:0];
    wire [7:0] psw_rd   = {psw_ff[7:1], ^acc_ff};
    wire [7:0] ri_addr  = {3'b000, psw_ff[4:3], 2'b00, op_ff[0]};
    wire [7:0] rn_addr  = {3'b000, psw_ff[4:3], op_ff[2:0]};
    wire [7:0] mem_addr = op_ff[3] ? rn_addr : iram[ri_addr];
    wire [7:0] mem_val  = iram[mem_addr];
    wire       logic_g  = (hi == `AIE_GRP_AND) || (hi == `AIE_GRP_OR) ||
                          (hi == `AIE_GRP_XOR);
    wire       arith_g  = (hi == `AIE_GRP_ADD) ||
                          (hi == `AIE_GRP_ADD_WITH_CARRY) || (hi == `AIE_GRP_SUBTRACT_WITH_BORROW);
    wire       step_g   = (hi == `AIE_GRP_INC) || (hi == `AIE_GRP_DEC);
    wire       to_dir   = (logic_g && lo < 4'h4) || (step_g && lo == 4'h5);
    wire       to_mem   = step_g && lo >= 4'h6;

    // Upper direct space is registers, not memory; unmapped reads 0
    reg  [7:0] dir_rd;
    always @* begin
        if (!opnd1_ff[7]) begin
            dir_rd = iram[opnd1_ff];
        end else if (opnd1_ff == `AIE_SFR_ACC) begin
            dir_rd = acc_ff;
        end else if (opnd1_ff == `AIE_SFR_B) begin
            dir_rd = b_ff;
        end else if (opnd1_ff == `AIE_SFR_PSW) begin
            dir_rd = psw_rd;
        end else if (opnd1_ff == `AIE_SFR_DPL) begin
            dir_rd = data_pointer_16_ff[7:0];
        end else if (opnd1_ff == `AIE_SFR_DPH) begin
            dir_rd = data_pointer_16_ff[15:8];
        end else begin
            dir_rd = 8'h00;
        end
    end

    wire [7:0] src = (lo == 4'h4) ? opnd1_ff :
                     (lo == 4'h5) ? dir_rd : mem_val;

    // ************************************************************
    // Arithmetic
    // ************************************************************
    reg  [3:0] alu_op;
    reg  [7:0] alu_a;
    reg  [7:0] alu_b;
    wire [7:0] alu_res;
    wire       alu_cy;
    wire       alu_ac;
    wire       alu_ov;

    always @* begin
        alu_a = acc_ff;
        alu_b = src;
        case (hi)
            `AIE_GRP_ADD:  alu_op = `AIE_ALU_ADD;
            `AIE_GRP_ADD_WITH_CARRY: alu_op = `AIE_ALU_ADD_WITH_CARRY;
            `AIE_GRP_SUBTRACT_WITH_BORROW: alu_op = `AIE_ALU_SUBTRACT_WITH_BORROW;
            `AIE_GRP_AND:  alu_op = `AIE_ALU_AND;
            `AIE_GRP_OR:   alu_op = `AIE_ALU_OR;
            `AIE_GRP_XOR:  alu_op = `AIE_ALU_XOR;
            `AIE_GRP_INC:  alu_op = `AIE_ALU_INC;
            `AIE_GRP_DEC:  alu_op = `AIE_ALU_DEC;
            default:       alu_op = `AIE_ALU_DA;
        endcase
        if (logic_g && lo < 4'h4) begin
            alu_a = dir_rd;
            alu_b = (lo == 4'h2) ? acc_ff : opnd2_ff;
        end else if (step_g && lo != 4'h4) begin
            alu_a = src;
        end
    end

    aie_alu u_alu (
        .a_i   (alu_a),
        .b_i   (alu_b),
        .cy_i  (psw_ff[`AIE_PSW_CY]),
        .ac_i  (psw_ff[`AIE_PSW_AC]),
        .op_i  (alu_op),
        .res_o (alu_res),
        .cy_o  (alu_cy),
        .ac_o  (alu_ac),
        .ov_o  (alu_ov)
    );

    wire [15:0] prod = acc_ff * b_ff;
    wire [7:0]  quot = (b_ff == 8'h00) ? 8'h00 : acc_ff / b_ff;
    wire [7:0]  rem  = (b_ff == 8'h00) ? 8'h00 : acc_ff % b_ff;

    // ************************************************************
    // Write back on the last machine cycle
    // ************************************************************
    reg  [7:0] nxt_acc;
    reg  [7:0] nxt_b;
    reg  [7:0] nxt_psw;
    reg [15:0] nxt_data_pointer_16;
    reg        wr_en;
    reg  [7:0] wr_addr;
    reg  [7:0] wr_data;
    reg  [7:0] dst_addr;

    always @* begin
        nxt_acc  = acc_ff;
        nxt_b    = b_ff;
        nxt_psw  = psw_ff;
        nxt_data_pointer_16 = data_pointer_16_ff;
        wr_en    = 1'b0;
        wr_addr  = 8'h00;
        wr_data  = 8'h00;
        dst_addr = to_mem ? mem_addr : opnd1_ff;
        if (commit && legal_ff) begin
            if (op_ff == `AIE_OP_INC_DATA_POINTER_16) begin
                nxt_data_pointer_16 = data_pointer_16_ff + 16'h0001;
            end else if (op_ff == `AIE_OP_MUL) begin
                nxt_acc = prod[7:0];
                nxt_b   = prod[15:8];
                nxt_psw[`AIE_PSW_CY] = 1'b0;
                nxt_psw[`AIE_PSW_OV] = |prod[15:8];
            end else if (op_ff == `AIE_OP_DIV) begin
                // Divide by zero leaves A and B untouched, flags OV
                if (b_ff != 8'h00) begin
                    nxt_acc = quot;
                    nxt_b   = rem;
                end
                nxt_psw[`AIE_PSW_CY] = 1'b0;
                nxt_psw[`AIE_PSW_OV] = (b_ff == 8'h00);
            end else if (op_ff == `AIE_OP_CLR_A) begin
                nxt_acc = 8'h00;
            end else if (op_ff == `AIE_OP_DA) begin
                nxt_acc = alu_res;
                nxt_psw[`AIE_PSW_CY] = alu_cy;
            end else if (to_mem || (to_dir && !opnd1_ff[7])) begin
                wr_en   = 1'b1;
                wr_addr = dst_addr;
                wr_data = alu_res;
            end else if (to_dir) begin
                if (opnd1_ff == `AIE_SFR_ACC) begin
                    nxt_acc = alu_res;
                end else if (opnd1_ff == `AIE_SFR_B) begin
                    nxt_b = alu_res;
                end else if (opnd1_ff == `AIE_SFR_PSW) begin
                    nxt_psw = alu_res;
                end else if (opnd1_ff == `AIE_SFR_DPL) begin
                    nxt_data_pointer_16[7:0] = alu_res;
                end else if (opnd1_ff == `AIE_SFR_DPH) begin
                    nxt_data_pointer_16[15:8] = alu_res;
                end
            end else begin
                nxt_acc = alu_res;
                if (arith_g) begin
                    nxt_psw[`AIE_PSW_CY] = alu_cy;
                    nxt_psw[`AIE_PSW_AC] = alu_ac;
                    nxt_psw[`AIE_PSW_OV] = alu_ov;
                end
            end
        end
    end

    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff  <= `AIE_RST_ACC;
            b_ff    <= `AIE_RST_B;
            psw_ff  <= `AIE_RST_PSW;
            data_pointer_16_ff <= `AIE_RST_DATA_POINTER_16;
        end else begin
            acc_ff  <= nxt_acc;
            b_ff    <= nxt_b;
            psw_ff  <= nxt_psw;
            data_pointer_16_ff <= nxt_data_pointer_16;
        end
    end

    // Memory has no reset; the load port is honoured only while idle
    always @(posedge clk_sys_i) begin
        if (wr_en) begin
            iram[wr_addr] <= wr_data;
        end else if (mem_wr_i && !busy_ff) begin
            iram[mem_addr_i] <= mem_wdata_i;
        end
        mem_rdata_ff <= iram[mem_addr_i];
    end

    assign done_o         = done_ff;
    assign illegal_o      = illegal_ff;
    assign instr_len_o    = len_ff;
    assign instr_cycles_o = cyc_ff;
    assign rel_offset_o   = rel_ff;
    assign acc_o          = acc_ff;
    assign b_o            = b_ff;
    assign psw_o          = psw_rd;
    assign data_pointer_16_o         = data_pointer_16_ff;
    assign mem_rdata_o    = mem_rdata_ff;

endmodule

// ===== sim/aie_exec_chk.sv
// Checker for the execution block: issue handshake, timing, lengths.
// Bound to aie_exec; sees its ports only.
`timescale 1ns/100ps
module aie_exec_chk #(
    parameter [7:0] MC_CLKS = 8'h0c
) (
    // Clock and reset
    input wire        clk_sys_i,
    input wire        rstn_i,
    // Issue
    input wire        instr_valid_i,
    input wire        instr_ready_o,
    input wire [7:0]  opcode_i,
    input wire [7:0]  operand1_i,
    // Results
    input wire        done_o,
    input wire        illegal_o,
    input wire [1:0]  instr_len_o,
    input wire [2:0]  instr_cycles_o,
    input wire [15:0] rel_offset_o,
    input wire [7:0]  acc_o,
    input wire [7:0]  psw_o
);
    // ****************************************************************
    // Clocks since take
    // ****************************************************************
    wire       take = instr_valid_i & instr_ready_o;
    reg  [7:0] wait_ff;
    // Wraps while idle, harmless: done never comes without a take
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i)
            wait_ff <= 8'h00;
        else if (take)
            wait_ff <= 8'h00;
        else
            wait_ff <= wait_ff + 8'h01;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    a_done_latency: assert property (
        done_o |-> wait_ff == instr_cycles_o * MC_CLKS)
        else $error("done not after cycles times clocks");
    a_take_busy: assert property (
        take |=> !instr_ready_o [*2]) else $error("ready after take");
    a_ready_done: assert property (
        done_o |-> instr_ready_o) else $error("not ready at done");
    a_illegal_done: assert property (
        illegal_o |-> done_o) else $error("illegal without done");
    a_rel_sign: assert property (
        take |=> rel_offset_o == {{8{$past(operand1_i[7])}},
        $past(operand1_i)}) else $error("offset not sign extended");
    a_arith_len: assert property (
        take && opcode_i[7:4] inside {4'h2, 4'h3, 4'h9} &&
        opcode_i[3:0] >= 4'h4 |=> instr_cycles_o == 3'h1 &&
        instr_len_o == ($past(opcode_i[3:1]) == 3'h2 ? 2'h2 : 2'h1))
        else $error("arithmetic length or cycles wrong");
    a_dir_imm: assert property (
        take && opcode_i inside {8'h43, 8'h53, 8'h63} |=>
        instr_len_o == 2'h3 && instr_cycles_o == 3'h2)
        else $error("direct immediate logic length wrong");
    a_acc_dir: assert property (
        take && opcode_i inside {8'h42, 8'h52, 8'h62} |=>
        instr_len_o == 2'h2 && instr_cycles_o == 3'h1)
        else $error("accumulator to direct length wrong");
    a_xor_src: assert property (
        take && opcode_i inside {[8'h66:8'h6f]} |=>
        instr_len_o == 2'h1 && instr_cycles_o == 3'h1)
        else $error("xor register length wrong");
    a_muldiv: assert property (
        take && opcode_i inside {8'ha4, 8'h84} |=>
        instr_len_o == 2'h1 && instr_cycles_o == 3'h4)
        else $error("multiply or divide timing wrong");
    a_inc_data_pointer_16: assert property (
        take && opcode_i == 8'ha3 |=> instr_cycles_o == 3'h2)
        else $error("pointer increment cycles wrong");
    a_parity: assert property (
        psw_o[0] == ^acc_o) else $error("parity bit wrong");
endmodule

bind aie_exec aie_exec_chk #(.MC_CLKS(MC_CLKS)) u_chk (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o),
    .opcode_i(opcode_i), .operand1_i(operand1_i), .done_o(done_o),
    .illegal_o(illegal_o), .instr_len_o(instr_len_o),
    .instr_cycles_o(instr_cycles_o), .rel_offset_o(rel_offset_o),
    .acc_o(acc_o), .psw_o(psw_o));

// ===== sim/aie_exec_tb.sv
// Self-checking bench for the execution block.
// Short machine cycle (2 clocks) keeps the run brief.
`timescale 1ns/100ps
module aie_exec_tb;
    localparam [7:0] MCK = 8'h02;
    logic        clk_sys_i, rstn_i, instr_valid_i, mem_wr_i, exp_ill;
    logic [7:0]  opcode_i, operand1_i, operand2_i, mem_addr_i, mem_wdata_i;
    wire         instr_ready_o, done_o, illegal_o;
    wire  [1:0]  instr_len_o;
    wire  [2:0]  instr_cycles_o;
    wire  [15:0] rel_offset_o, data_pointer_16_o;
    wire  [7:0]  acc_o, b_o, psw_o, mem_rdata_o;
    integer      errors, cmp_count, cyc_cnt;

    aie_exec #(.MC_CLKS(MCK)) dut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o),
        .opcode_i(opcode_i), .operand1_i(operand1_i),
        .operand2_i(operand2_i), .done_o(done_o), .illegal_o(illegal_o),
        .instr_len_o(instr_len_o), .instr_cycles_o(instr_cycles_o),
        .rel_offset_o(rel_offset_o), .acc_o(acc_o), .b_o(b_o),
        .psw_o(psw_o), .data_pointer_16_o(data_pointer_16_o), .mem_wr_i(mem_wr_i),
        .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i),
        .mem_rdata_o(mem_rdata_o));

    // ****************************************************************
    // Clock, timeout and common tasks
    // ****************************************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // About 25 instructions of a few clocks each; ample margin
    always @(posedge clk_sys_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 3000) begin
            errors = errors + 1;
            stop_test;
        end
    end
    task automatic check(input string name, input logic [15:0] seen, exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic mem_put(input logic [7:0] a, d);
        @(posedge clk_sys_i);
        mem_wr_i <= 1'b1;
        mem_addr_i <= a;
        mem_wdata_i <= d;
        @(posedge clk_sys_i);
        mem_wr_i <= 1'b0;
    endtask
    task automatic mem_chk(input logic [7:0] a, e);
        @(posedge clk_sys_i);
        mem_addr_i <= a;
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check("memory", mem_rdata_o, e);
    endtask
    // Issue one instruction, time its completion and judge the result
    task automatic run(input logic [7:0] op, o1, o2, input logic [1:0] ln,
                       input logic [2:0] cy, input logic [7:0] ea);
        integer n;
        n = 0;
        @(negedge clk_sys_i);
        while (instr_ready_o !== 1'b1 && n < 100) begin
            @(negedge clk_sys_i);
            n = n + 1;
        end
        @(posedge clk_sys_i);
        instr_valid_i <= 1'b1;
        opcode_i <= op;
        operand1_i <= o1;
        operand2_i <= o2;
        @(posedge clk_sys_i);
        instr_valid_i <= 1'b0;
        n = 0;
        @(negedge clk_sys_i);
        while (done_o !== 1'b1 && n < 100) begin
            @(negedge clk_sys_i);
            n = n + 1;
        end
        check("latency", n, cy * MCK);
        check("illegal", illegal_o, exp_ill);
        check("length", instr_len_o, ln);
        check("cycles", instr_cycles_o, cy);
        check("acc", acc_o, ea);
        check("offset", rel_offset_o, {{8{o1[7]}}, o1});
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset;
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check("ready", instr_ready_o, 1'b0);
        check("acc", acc_o, 8'h00);
        check("psw", psw_o, 8'h00);
        check("b", b_o, 8'h00);
        check("data_pointer_16", data_pointer_16_o, 16'h0000);
        @(posedge clk_sys_i);
        rstn_i <= 1'b1;
    endtask
    task t_arith;
        mem_put(8'h00, 8'h10);
        mem_put(8'h02, 8'h01);
        mem_put(8'h10, 8'hff);
        run(8'he4, 8'h00, 8'h00, 2'h1, 3'h1, 8'h00);
        run(8'h24, 8'h05, 8'h00, 2'h2, 3'h1, 8'h05);
        run(8'h24, 8'hff, 8'h00, 2'h2, 3'h1, 8'h04);
        check("carry", psw_o[7], 1'b1);
        run(8'h34, 8'h10, 8'h00, 2'h2, 3'h1, 8'h15);
        run(8'h94, 8'h16, 8'h00, 2'h2, 3'h1, 8'hff);
        check("borrow", psw_o[7], 1'b1);
        run(8'h9a, 8'h00, 8'h00, 2'h1, 3'h1, 8'hfd);
        check("borrow", psw_o[7], 1'b0);
    endtask
    task t_logic;
        run(8'h54, 8'h0f, 8'h00, 2'h2, 3'h1, 8'h0d);
        run(8'h44, 8'h30, 8'h00, 2'h2, 3'h1, 8'h3d);
        run(8'h6a, 8'h00, 8'h00, 2'h1, 3'h1, 8'h3c);
        run(8'h66, 8'h00, 8'h00, 2'h1, 3'h1, 8'hc3);
        run(8'h65, 8'h10, 8'h00, 2'h2, 3'h1, 8'h3c);
    endtask
    task t_direct;
        run(8'h53, 8'h10, 8'hf0, 2'h3, 3'h2, 8'h3c);
        mem_chk(8'h10, 8'hf0);
        run(8'h43, 8'h10, 8'h05, 2'h3, 3'h2, 8'h3c);
        mem_chk(8'h10, 8'hf5);
        run(8'h63, 8'h10, 8'hff, 2'h3, 3'h2, 8'h3c);
        mem_chk(8'h10, 8'h0a);
        run(8'h62, 8'h10, 8'h00, 2'h2, 3'h1, 8'h3c);
        mem_chk(8'h10, 8'h36);
    endtask
    task t_incdec;
        mem_put(8'h11, 8'hff);
        run(8'h05, 8'h11, 8'h00, 2'h2, 3'h1, 8'h3c);
        mem_chk(8'h11, 8'h00);
        run(8'h15, 8'h11, 8'h00, 2'h2, 3'h1, 8'h3c);
        mem_chk(8'h11, 8'hff);
        run(8'h06, 8'h00, 8'h00, 2'h1, 3'h1, 8'h3c);
        mem_chk(8'h10, 8'h37);
        run(8'ha3, 8'h00, 8'h00, 2'h1, 3'h2, 8'h3c);
        check("data_pointer_16", data_pointer_16_o, 16'h0001);
    endtask
    task t_muldiv;
        run(8'h43, 8'hf0, 8'h07, 2'h3, 3'h2, 8'h3c);
        check("b", b_o, 8'h07);
        run(8'ha4, 8'h00, 8'h00, 2'h1, 3'h4, 8'ha4);
        check("b", b_o, 8'h01);
        check("overflow", psw_o[2], 1'b1);
        run(8'h84, 8'h00, 8'h00, 2'h1, 3'h4, 8'ha4);
        check("b", b_o, 8'h00);
        check("overflow", psw_o[2], 1'b0);
        run(8'h84, 8'h00, 8'h00, 2'h1, 3'h4, 8'ha4);
        check("overflow", psw_o[2], 1'b1);
    endtask
    task t_illegal;
        exp_ill = 1'b1;
        run(8'ha5, 8'h80, 8'h00, 2'h1, 3'h1, 8'ha4);
        exp_ill = 1'b0;
        run(8'hd4, 8'h00, 8'h00, 2'h1, 3'h1, 8'h04);
        check("carry", psw_o[7], 1'b1);
    endtask

    initial begin
        errors = 0;
        cmp_count = 0;
        cyc_cnt = 0;
        exp_ill = 1'b0;
        rstn_i = 1'b0;
        instr_valid_i = 1'b0;
        mem_wr_i = 1'b0;
        opcode_i = 8'h00;
        operand1_i = 8'h00;
        operand2_i = 8'h00;
        mem_addr_i = 8'h00;
        mem_wdata_i = 8'h00;
        t_reset;
        t_arith;
        t_logic;
        t_direct;
        t_incdec;
        t_muldiv;
        t_illegal;
        stop_test;
    end
endmodule
